// [hw/bsto_sync_trig.v]
`timescale 1ns/100ps
`include "bsto_regs.vh"
module bsto_sync_trig
(
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Configuration levels
   input wire [2:0] outMode,
   input wire [1:0] trigSource,
   input wire syncEnable,
   input wire syncNegative,
   input wire trigOutEnable,
   input wire trigTrailing,
   input wire waveInvert,
   input wire [31:0] burstCycles,
   // Waveform engine events, same clock
   input wire burstStart,
   input wire carrierCycleEnd,
   input wire burstActive,
   input wire sweepStart,
   input wire sweepActive,
   input wire [31:0] trigHalfPeriod,
   // Manual trigger button pin, asynchronous
   input wire manualPin,
   // Shared connector and status
   output reg syncOut,
   output reg syncOutEn,
   output reg trigActive,
   output reg syncActive
);
   localparam ST_IDLE = 3'b001;
   localparam ST_HIGH = 3'b010;
   localparam ST_LOW = 3'b100;

   wire manualLevel;
   reg manualPrev;
   reg [2:0] trigState;
   reg [31:0] cycleCount;
   reg ncycHigh;
   reg [31:0] trigCount;
   reg trigLevel;
   reg lastEnable;
   reg trigEnPrev;
   wire trigEnRise;
   reg syncSel;
   reg next_syncSel;
   reg rawSync;
   reg rawTrig;
   reg trigAllowed;
   reg syncAllowed;
   wire manualEdge;
   wire startEvt;

   bsto_pin_sync uManual
   (
      .core_clk(core_clk),
      .nrst(nrst),
      .pinIn(manualPin),
      .level(manualLevel)
   );

   assign manualEdge = manualLevel & ~manualPrev;
   assign trigEnRise = trigOutEnable & ~trigEnPrev;
   assign startEvt = (outMode == `BSTO_MODE_SWEEP) ? sweepStart : burstStart;

   // Last cycle of a timed phase; a zero count ends it at once
   function phaseDone;
      input [31:0] cnt;
      begin
         phaseDone = (cnt <= 32'h0000_0001);
      end
   endfunction

   function [31:0] countDown;
      input [31:0] cnt;
      begin
         countDown = cnt - 32'h0000_0001;
      end
   endfunction

   // Wraps at the top of the range; burst lengths never get near it
   function [31:0] countUp;
      input [31:0] cnt;
      begin
         countUp = cnt + 32'h0000_0001;
      end
   endfunction

   // Most recently enabled function wins the shared connector
   always @*
   begin
      next_syncSel = syncSel;
      if (syncEnable && !lastEnable)
         next_syncSel = 1'b1;
      else if (trigOutEnable && !syncEnable)
         next_syncSel = 1'b0;
      else if (syncEnable && !trigOutEnable)
         next_syncSel = 1'b1;
      else if (trigOutEnable && syncEnable && syncSel && trigEnRise)
         next_syncSel = 1'b0;
   end

   always @*
   begin
      trigAllowed = trigOutEnable && !next_syncSel &&
         trigSource != `BSTO_SRC_EXT &&
         (outMode == `BSTO_MODE_SWEEP || outMode == `BSTO_MODE_INF ||
          outMode == `BSTO_MODE_NCYC || outMode == `BSTO_MODE_GATED);
      syncAllowed = syncEnable && next_syncSel &&
         trigSource != `BSTO_SRC_EXT &&
         outMode != `BSTO_MODE_GATED;
      case (outMode)
         `BSTO_MODE_INF: rawSync = burstActive;
         `BSTO_MODE_NCYC: rawSync = ncycHigh;
         `BSTO_MODE_SWEEP: rawSync = sweepActive;
         default: rawSync = 1'b0;
      endcase
      // Trailing edge select marks the start with a falling edge
      rawTrig = trigLevel ^ trigTrailing;
   end

   // Counted burst: high from the start until N carrier cycles pass
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         cycleCount <= 32'h0000_0000;
         ncycHigh <= 1'b0;
      end
      else if (burstStart)
      begin
         cycleCount <= 32'h0000_0000;
         ncycHigh <= 1'b1;
      end
      else if (ncycHigh && carrierCycleEnd)
      begin
         cycleCount <= countUp(cycleCount);
         if (countUp(cycleCount) >= burstCycles)
            ncycHigh <= 1'b0;
      end
   end

   // Trigger generator: square per start (internal) or one pulse (manual)
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         trigState <= ST_IDLE;
         trigCount <= 32'h0000_0000;
         trigLevel <= 1'b0;
         manualPrev <= 1'b0;
      end
      else
      begin
         manualPrev <= manualLevel;
         case (trigState)
            ST_IDLE:
            begin
               trigLevel <= 1'b0;
               if (startEvt && trigSource == `BSTO_SRC_INT)
               begin
                  trigState <= ST_HIGH;
                  trigLevel <= 1'b1;
                  trigCount <= trigHalfPeriod;
               end
               else if (manualEdge && trigSource == `BSTO_SRC_MAN)
               begin
                  trigState <= ST_HIGH;
                  trigLevel <= 1'b1;
                  trigCount <= `BSTO_PULSE_CYC;
               end
            end
            ST_HIGH:
            begin
               if (phaseDone(trigCount))
               begin
                  trigLevel <= 1'b0;
                  if (trigSource == `BSTO_SRC_INT)
                  begin
                     trigState <= ST_LOW;
                     trigCount <= trigHalfPeriod;
                  end
                  else
                     trigState <= ST_IDLE;
               end
               else
                  trigCount <= countDown(trigCount);
            end
            ST_LOW:
            begin
               if (phaseDone(trigCount))
                  trigState <= ST_IDLE;
               else
                  trigCount <= countDown(trigCount);
            end
            default:
            begin
               trigState <= ST_IDLE;
               trigLevel <= 1'b0;
            end
         endcase
      end
   end

   // Connector drive; waveform invert is deliberately not used here
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         syncSel <= 1'b0;
         lastEnable <= 1'b0;
         trigEnPrev <= 1'b0;
         syncOut <= 1'b0;
         syncOutEn <= 1'b0;
         trigActive <= 1'b0;
         syncActive <= 1'b0;
      end
      else
      begin
         syncSel <= next_syncSel;
         lastEnable <= syncEnable;
         trigEnPrev <= trigOutEnable;
         trigActive <= trigAllowed;
         syncActive <= syncAllowed;
         syncOutEn <= trigAllowed | syncAllowed;
         if (syncAllowed)
            syncOut <= rawSync ^ syncNegative;
         else if (trigAllowed)
            syncOut <= rawTrig;
         else
            syncOut <= 1'b0;
      end
   end
endmodule

// [hw/bsto_regs.vh]
// How it works
// - Infinite burst holds sync high throughout
// - Counted burst: sync high until N cycles
// - Internal counted: sync period equals burst period
// - Gated burst gives no sync
// - External trigger source disables sync
// - Burst/sweep internal/manual: trigger out on connector
// - Internal trigger: half-duty square per start
// - Manual trigger: single pulse above 4 us
// - External source disables trigger output
// - Sync enable turns trigger output off
// - Trigger on/off plus leading/trailing edge select
// - Waveform invert never touches sync polarity
// - Sync polarity selects normal or inverse
// - Trigger enable turns sync output off
`ifndef BSTO_REGS_VH
`define BSTO_REGS_VH
`define BSTO_MODE_CONT 3'h0
`define BSTO_MODE_INF 3'h1
`define BSTO_MODE_NCYC 3'h2
`define BSTO_MODE_GATED 3'h3
`define BSTO_MODE_SWEEP 3'h4
`define BSTO_SRC_INT 2'h0
`define BSTO_SRC_EXT 2'h1
`define BSTO_SRC_MAN 2'h2
`define BSTO_CLK_NS 10
`define BSTO_PULSE_NS 5000
`define BSTO_PULSE_CYC ((`BSTO_PULSE_NS + `BSTO_CLK_NS - 1) / `BSTO_CLK_NS + 1)
`define BSTO_CNT_W 32
`endif

// [hw/bsto_pin_sync.v]
`timescale 1ns/100ps
`include "bsto_regs.vh"
module bsto_pin_sync
(
   // Clock and reset
   input wire core_clk,
   input wire nrst,
   // Asynchronous pin and clean level
   input wire pinIn,
   output reg level
);
   reg s1;
   reg s2;
   reg s3;

   // Level changes only once the second and third stages agree
   always @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         level <= 1'b0;
      end
      else
      begin
         s1 <= pinIn;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3)
            level <= s3;
      end
   end
endmodule

// [verification/bsto_probe.sv]
`timescale 1ns/100ps
module bsto_probe
(
   // Instrument input and measurements
   input wire clk,
   input wire line,
   input wire en,
   output int rises = 0,
   output int width = 0
);
   // A connector that is not driven reads as low at a terminated input
   wire hi = en && line;
   int run = 0;
   always @(posedge clk)
   begin
      run <= hi ? run + 1 : 0;
      if (hi && run == 0)
         rises <= rises + 1;
      if (!hi && run != 0)
         width <= run;
   end
endmodule

// [verification/bsto_sync_trig_checker.sv]
`timescale 1ns/100ps
module bsto_sync_trig_checker
(
   // Clock and reset
   input logic core_clk,
   input logic nrst,
   // Configuration and engine state
   input logic [2:0] outMode,
   input logic [1:0] trigSource,
   input logic syncEnable,
   input logic syncNegative,
   input logic trigOutEnable,
   input logic trigTrailing,
   input logic burstActive,
   input logic [31:0] trigHalfPeriod,
   // Connector
   input logic syncOut,
   input logic syncOutEn,
   input logic trigActive,
   input logic syncActive
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!nrst);
   wire ext = trigSource == 2'h1;
   wire infOn = outMode == 3'h1 && burstActive && syncEnable && !ext
      && !trigOutEnable && !syncNegative;
   sequence sqHigh;
      syncOut [*3] ##1 !syncOut;
   endsequence
   a_ext_sync_off:
   assert property (ext [*3] |=> !syncOutEn) else $error("sync on ext");
   a_ext_trig_off:
   assert property (ext [*3] |=> !trigActive) else $error("trig on ext");
   a_owner_excl:
   assert property (!(syncActive && trigActive)) else $error("two owners");
   a_trig_off_idle:
   assert property (!trigOutEnable [*3] |=> !trigActive) else $error("trig");
   a_gated_silent:
   assert property ((outMode == 3'h3 && !syncNegative && !trigOutEnable)
      [*3] |=> !syncOut) else $error("gated sync");
   a_inf_high:
   assert property (infOn [*3] |=> syncOut && syncOutEn) else $error("inf");
   a_int_square:
   assert property ($rose(syncOut) && trigActive && !trigTrailing
      && trigSource == 2'h0 && trigHalfPeriod == 32'h0000_0004 |=> sqHigh)
      else $error("square width");
   a_reset_quiet:
   assert property ($rose(nrst) |-> !syncOutEn && !syncOut) else $error("rst");
endmodule
bind bsto_sync_trig bsto_sync_trig_checker bsto_sync_trig_checker_inst
   (.core_clk, .nrst, .outMode, .trigSource, .syncEnable, .syncNegative,
   .trigOutEnable, .trigTrailing, .burstActive, .trigHalfPeriod, .syncOut,
   .syncOutEn, .trigActive, .syncActive);

// [verification/testbench.sv]
`timescale 1ns/100ps
module testbench;
   logic core_clk = 1'b0, nrst = 1'b0, syncEnable = 1'b0;
   logic [2:0] outMode = 3'h0;
   logic [1:0] trigSource = 2'h0;
   logic syncNegative = 1'b0, trigOutEnable = 1'b0, trigTrailing = 1'b0;
   logic waveInvert = 1'b0, burstStart = 1'b0, carrierCycleEnd = 1'b0;
   logic burstActive = 1'b0, sweepStart = 1'b0, sweepActive = 1'b0;
   logic manualPin = 1'b0;
   logic [31:0] burstCycles = 32'h0000_0003, trigHalfPeriod = 32'h0000_0004;
   wire syncOut, syncOutEn, trigActive, syncActive;
   int rises, width, r0, fails = 0, num_checks = 0;
   always #5 core_clk = ~core_clk;
   bsto_sync_trig bsto_sync_trig_inst (.core_clk, .nrst, .outMode,
      .trigSource, .syncEnable, .syncNegative, .trigOutEnable, .trigTrailing,
      .waveInvert, .burstCycles, .burstStart, .carrierCycleEnd, .burstActive,
      .sweepStart, .sweepActive, .trigHalfPeriod, .manualPin, .syncOut,
      .syncOutEn, .trigActive, .syncActive);
   bsto_probe bsto_probe_inst (.clk(core_clk), .line(syncOut),
      .en(syncOutEn), .rises(rises), .width(width));
   task wt(input int n);
      repeat (n) @(negedge core_clk);
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         fails++;
         $display("[ERR] %s exp %0h got %0h", nm, e, g);
      end
   endtask
   task cfg(input logic [2:0] m, input logic [1:0] s, input logic se, te);
      outMode = m;
      trigSource = s;
      syncEnable = se;
      trigOutEnable = te;
      wt(4);
   endtask
   task start(input logic sw);
      {sweepStart, burstStart} = {sw, !sw};
      wt(1);
      {sweepStart, burstStart} = 2'h0;
   endtask
   // Three carrier cycles close the counted burst
   task burst3;
      start(0);
      wt(2);
      chk("ncycRise", 1, syncOut);
      repeat (3)
      begin
         chk("ncycHold", 1, syncOut);
         carrierCycleEnd = 1;
         wt(1);
         carrierCycleEnd = 0;
         wt(2);
      end
      chk("ncycFall", 0, syncOut);
   endtask
   task finish_test;
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial
   begin
      #50000;
      fails++;
      finish_test;
   end
   initial
   begin
      wt(10);
      nrst = 1;
      burstActive = 1;
      sweepActive = 1;
      cfg(3'h1, 2'h0, 1, 0);
      chk("infSync", 1, syncOut);
      waveInvert = 1;
      wt(3);
      chk("invSync", 1, syncOut);
      syncNegative = 1;
      wt(3);
      chk("negSync", 0, syncOut);
      syncNegative = 0;
      cfg(3'h2, 2'h0, 1, 0);
      r0 = rises;
      burst3;
      burst3;
      chk("ncycRate", 2, rises - r0);
      // Three carrier periods of three clocks each
      chk("ncycWidth", 9, width);
      cfg(3'h3, 2'h0, 1, 0);
      start(0);
      wt(3);
      chk("gated", 0, syncOut);
      cfg(3'h1, 2'h1, 1, 0);
      chk("extSync", 0, syncOutEn);
      cfg(3'h1, 2'h0, 0, 1);
      chk("trigOwn", 1, trigActive);
      chk("syncOff", 0, syncActive);
      r0 = rises;
      start(0);
      wt(12);
      chk("sqRise", 1, rises - r0);
      chk("sqHigh", 4, width);
      trigTrailing = 1;
      wt(3);
      chk("trailIdle", 1, syncOut);
      trigTrailing = 0;
      cfg(3'h4, 2'h0, 0, 1);
      r0 = rises;
      start(1);
      wt(12);
      chk("swTrig", 1, rises - r0);
      cfg(3'h1, 2'h2, 0, 1);
      r0 = rises;
      manualPin = 1;
      wt(5);
      manualPin = 0;
      wt(600);
      chk("manRise", 1, rises - r0);
      chk("manWide", 1, width > 400);
      cfg(3'h1, 2'h1, 0, 1);
      chk("extTrig", 0, trigActive);
      cfg(3'h1, 2'h0, 0, 1);
      cfg(3'h1, 2'h0, 1, 1);
      chk("syncWins", 0, trigActive);
      chk("syncOwns", 1, syncActive);
      cfg(3'h1, 2'h0, 1, 0);
      cfg(3'h1, 2'h0, 1, 1);
      chk("trigWins", 1, trigActive);
      chk("syncLoses", 0, syncActive);
      cfg(3'h0, 2'h0, 0, 1);
      chk("contTrig", 0, trigActive);
      finish_test;
   end
endmodule
